// file: logic/sd_host_interrupt_enables.v
// How it works
// [RQ1] normal status enable bits 2..0: block gap, transfer complete, command complete.
// [RQ2] card interrupt status enable at 0 clears all held card interrupt state.
// [RQ3] card interrupt level may be sampled and held in a flip-flop.
// [RQ4] error status enable at 1 lets that error flag set; 0 masks it.
// [RQ5] error status enable bits 15..12 vendor field read-write; 11..10 reserved.
// [RQ6] error enables: ADMA 9, auto stop 8, limit 7, data end/crc/timeout 6..4.
// [RQ7] error enables: command index 3, end bit 2, crc 1, timeout 0.
// [RQ8] software sets command timeout and crc enables to catch command line conflict.
// [RQ9] all normal signal enables feed one shared interrupt line.
// [RQ10] signal enable bit 15 reads 0, bits 14..9 reserved.
// [RQ11] signal enables: card int 8, removal 7, insertion 6, read 5, write 4.
// [RQ12] signal enables: DMA 3, block gap 2, transfer complete 1.
// [RQ13] clearing card interrupt status enable withdraws request and stops detection.
// [RQ14] interrupt high while any enabled flag set; every enable resets to 0.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "sd_irq_regs.vh"
module sd_host_interrupt_enables (
  input wire clk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire cmd_complete_evt,
  input wire xfer_complete_evt,
  input wire block_gap_evt,
  input wire dma_int_evt,
  input wire buf_write_ready_evt,
  input wire buf_read_ready_evt,
  input wire card_insert_evt,
  input wire card_remove_evt,
  input wire card_int_pin,
  input wire cmd_timeout_err_evt,
  input wire cmd_crc_err_evt,
  input wire cmd_end_bit_err_evt,
  input wire cmd_index_err_evt,
  input wire data_timeout_err_evt,
  input wire data_crc_err_evt,
  input wire data_end_bit_err_evt,
  input wire current_limit_err_evt,
  input wire auto_stop_err_evt,
  input wire adma_err_evt,
  input wire [3:0] vendor_err_evt,
  output wire irq
);

  // software-visible enables
  reg [15:0] norm_status_en_r;
  reg [15:0] norm_status_en_nxt;
  reg [15:0] err_status_en_r;
  reg [15:0] err_status_en_nxt;
  reg [15:0] norm_signal_en_r;
  reg [15:0] norm_signal_en_nxt;

  // bus answer, and the registered irq
  reg waitrequest_r;
  reg [31:0] readdata_r;
  reg [31:0] readdata_nxt;
  reg irq_r;

  // event vectors from the engines, clear vectors from bus writes
  reg [7:0] norm_evt;
  reg [15:0] err_evt;
  reg [7:0] norm_clear;
  reg [15:0] err_clear;

  wire [7:0] norm_flags;
  wire [15:0] err_flags;
  wire card_int_held;
  wire [15:0] norm_status;
  wire [15:0] nse_wdata;
  wire [15:0] nse_lanes;
  wire [15:0] ese_wdata;
  wire [15:0] ese_lanes;
  wire [15:0] sig_wdata;
  wire [15:0] sig_lanes;
  wire [15:0] nclr_wdata;
  wire [15:0] nclr_lanes;
  wire [15:0] eclr_wdata;
  wire [15:0] eclr_lanes;
  wire req;
  wire accept;
  wire wr_accept;
  wire hit_norm_status;
  wire hit_err_status;
  wire hit_norm_status_en;
  wire hit_err_status_en;
  wire hit_norm_signal_en;
  wire hit_norm_clear;
  wire hit_err_clear;
  wire irq_nxt;

  // bus handshake
  assign req = avs_read | avs_write;
  // one wait cycle, then a single accept cycle; the master holds until then
  assign accept = req & ~waitrequest_r;
  assign wr_accept = accept & avs_write;

  // byte offsets; two 16-bit registers share each 32-bit word but the one at 0x038, bit 1 picks the half
  localparam [9:0] NORM_STS_OFS = `NORM_STATUS_OFS;
  localparam [9:0] ERR_STS_OFS = `ERR_STATUS_OFS;
  localparam [9:0] NORM_STS_EN_OFS = `NORM_STATUS_EN_OFS;
  localparam [9:0] ERR_STS_EN_OFS = `ERR_STATUS_EN_OFS;
  localparam [9:0] NORM_SIG_EN_OFS = `NORM_SIGNAL_EN_OFS;
  localparam [9:0] NORM_CLR_OFS = `NORM_CLEAR_OFS;
  localparam [9:0] ERR_CLR_OFS = `ERR_CLEAR_OFS;

  // the half of the write data that a register sits in
  function [15:0] half16;
    input [31:0] word;
    input upper;
    begin
      if (upper) begin
        half16 = word[31:16];
      end else begin
        half16 = word[15:0];
      end
    end
  endfunction

  // byte enables of that half, one bit per data bit
  function [15:0] lanes16;
    input [3:0] be;
    input upper;
    reg [1:0] pair;
    begin
      if (upper) begin
        pair = be[3:2];
      end else begin
        pair = be[1:0];
      end
      lanes16 = {{8{pair[1]}}, {8{pair[0]}}};
    end
  endfunction

  // drop a register value into its half of the read word
  function [31:0] place16;
    input [31:0] word;
    input [15:0] val;
    input upper;
    begin
      if (upper) begin
        place16 = {val, word[15:0]};
      end else begin
        place16 = {word[31:16], val};
      end
    end
  endfunction

  // per-register data and lanes, so a write to one half never touches its neighbour
  assign nse_wdata = half16(avs_writedata, NORM_STS_EN_OFS[1]);
  assign nse_lanes = lanes16(avs_byteenable, NORM_STS_EN_OFS[1]);
  assign ese_wdata = half16(avs_writedata, ERR_STS_EN_OFS[1]);
  assign ese_lanes = lanes16(avs_byteenable, ERR_STS_EN_OFS[1]);
  assign sig_wdata = half16(avs_writedata, NORM_SIG_EN_OFS[1]);
  assign sig_lanes = lanes16(avs_byteenable, NORM_SIG_EN_OFS[1]);
  assign nclr_wdata = half16(avs_writedata, NORM_CLR_OFS[1]);
  assign nclr_lanes = lanes16(avs_byteenable, NORM_CLR_OFS[1]);
  assign eclr_wdata = half16(avs_writedata, ERR_CLR_OFS[1]);
  assign eclr_lanes = lanes16(avs_byteenable, ERR_CLR_OFS[1]);

  // word decode; low address bits ignored, the halves are told apart by byte enables
  assign hit_norm_status = (avs_address[9:2] == NORM_STS_OFS[9:2]);
  assign hit_err_status = (avs_address[9:2] == ERR_STS_OFS[9:2]);
  assign hit_norm_status_en = (avs_address[9:2] == NORM_STS_EN_OFS[9:2]);
  assign hit_err_status_en = (avs_address[9:2] == ERR_STS_EN_OFS[9:2]);
  assign hit_norm_signal_en = (avs_address[9:2] == NORM_SIG_EN_OFS[9:2]);
  assign hit_norm_clear = (avs_address[9:2] == NORM_CLR_OFS[9:2]);
  assign hit_err_clear = (avs_address[9:2] == ERR_CLR_OFS[9:2]);

  // masked merge: unwritable bits keep their value, which is always zero
  function [15:0] merge16;
    input [15:0] old_val;
    input [15:0] wdata;
    input [15:0] lanes;
    input [15:0] wmask;
    reg [15:0] sel;
    begin
      sel = lanes & wmask;
      merge16 = (old_val & ~sel) | (wdata & sel);
    end
  endfunction

  // gather the engine events by bit position
  always @* begin
    norm_evt = 8'h00;
    norm_evt[`B_CMD_DONE] = cmd_complete_evt;
    norm_evt[`B_XFER_DONE] = xfer_complete_evt;
    norm_evt[`B_BLOCK_GAP] = block_gap_evt;
    norm_evt[`B_DMA_INT] = dma_int_evt;
    norm_evt[`B_BUF_WR_RDY] = buf_write_ready_evt;
    norm_evt[`B_BUF_RD_RDY] = buf_read_ready_evt;
    norm_evt[`B_CARD_INS] = card_insert_evt;
    norm_evt[`B_CARD_REM] = card_remove_evt;
  end

  always @* begin
    err_evt = 16'h0000;
    err_evt[`E_CMD_TIMEOUT] = cmd_timeout_err_evt;
    err_evt[`E_CMD_CRC] = cmd_crc_err_evt;
    err_evt[`E_CMD_END_BIT] = cmd_end_bit_err_evt;
    err_evt[`E_CMD_INDEX] = cmd_index_err_evt;
    err_evt[`E_DATA_TIMEOUT] = data_timeout_err_evt;
    err_evt[`E_DATA_CRC] = data_crc_err_evt;
    err_evt[`E_DATA_END_BIT] = data_end_bit_err_evt;
    err_evt[`E_CUR_LIMIT] = current_limit_err_evt;
    err_evt[`E_AUTO_STOP] = auto_stop_err_evt;
    err_evt[`E_ADMA] = adma_err_evt;
    err_evt[`E_VENDOR_MSB:`E_VENDOR_LSB] = vendor_err_evt;
  end

  // write-one-to-clear pulses, live only in the accept cycle
  always @* begin
    norm_clear = 8'h00;
    err_clear = 16'h0000;
    if (wr_accept && hit_norm_clear) begin
      norm_clear = nclr_wdata[7:0] & nclr_lanes[7:0];
    end
    if (wr_accept && hit_err_clear) begin
      err_clear = eclr_wdata & eclr_lanes;
    end
  end

  // normal flags 7..0, gated by the status enable at the moment of the event
  event_flag_bank #(
    .WIDTH(8)
  ) u_norm_flags (
    .clk(clk),
    .rst_n(rst_n),
    .event_in(norm_evt),
    .status_en(norm_status_en_r[7:0]), // [RQ1]
    .clear_in(norm_clear),
    .flags(norm_flags)
  );

  // error flags; reserved enable bits stay 0, so bits 11..10 never set
  event_flag_bank #(
    .WIDTH(16)
  ) u_err_flags (
    .clk(clk),
    .rst_n(rst_n),
    .event_in(err_evt),
    .status_en(err_status_en_r), // [RQ4]
    .clear_in(err_clear),
    .flags(err_flags)
  );

  // card interrupt is a level from the card, not a sticky event
  card_int_sampler u_card_int (
    .clk(clk),
    .rst_n(rst_n),
    .card_int_pin(card_int_pin),
    .detect_en(norm_status_en_r[`B_CARD_INT]), // [RQ2] [RQ13]
    .card_int_held(card_int_held)
  );

  assign norm_status = {7'h00, card_int_held, norm_flags} & `NORM_STATUS_MASK;

  // enable register updates
  always @* begin
    norm_status_en_nxt = norm_status_en_r;
    err_status_en_nxt = err_status_en_r;
    norm_signal_en_nxt = norm_signal_en_r;
    if (wr_accept && hit_norm_status_en) begin
      norm_status_en_nxt = merge16(norm_status_en_r, nse_wdata, nse_lanes,
                                   `NORM_STATUS_EN_MASK); // [RQ1] [RQ13]
    end
    if (wr_accept && hit_err_status_en) begin
      // vendor field 15..12 and bits 9..0 writable, 11..10 held at 0
      err_status_en_nxt = merge16(err_status_en_r, ese_wdata, ese_lanes,
                                  `ERR_STATUS_EN_MASK); // [RQ5] [RQ6] [RQ7]
    end
    if (wr_accept && hit_norm_signal_en) begin
      // bit 15 and 14..9 are outside the mask and always read 0
      norm_signal_en_nxt = merge16(norm_signal_en_r, sig_wdata, sig_lanes,
                                   `NORM_SIGNAL_EN_MASK); // [RQ10] [RQ11] [RQ12]
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      norm_status_en_r <= `REG_RESET; // [RQ14]
      err_status_en_r <= `REG_RESET; // [RQ14]
      norm_signal_en_r <= `REG_RESET; // [RQ14]
    end else begin
      norm_status_en_r <= norm_status_en_nxt;
      err_status_en_r <= err_status_en_nxt;
      norm_signal_en_r <= norm_signal_en_nxt;
    end
  end

  // read mux; both halves of a word fill in, clear and unmapped halves read 0
  // reads ignore byte enables: no register here has a read side effect
  always @* begin
    readdata_nxt = 32'h00000000;
    if (hit_norm_status) begin
      readdata_nxt = place16(readdata_nxt, norm_status, NORM_STS_OFS[1]);
    end
    if (hit_err_status) begin
      readdata_nxt = place16(readdata_nxt, err_flags, ERR_STS_OFS[1]);
    end
    if (hit_norm_status_en) begin
      readdata_nxt = place16(readdata_nxt, norm_status_en_r, NORM_STS_EN_OFS[1]);
    end
    if (hit_err_status_en) begin
      readdata_nxt = place16(readdata_nxt, err_status_en_r, ERR_STS_EN_OFS[1]);
    end
    if (hit_norm_signal_en) begin
      readdata_nxt = place16(readdata_nxt, norm_signal_en_r, NORM_SIG_EN_OFS[1]);
    end
  end

  // waitrequest: high at rest, low for exactly the accept cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h00000000;
    end else begin
      waitrequest_r <= ~(req & waitrequest_r);
      // captured one cycle early so the data stand through the accept edge
      if (avs_read && waitrequest_r) begin
        readdata_r <= readdata_nxt;
      end
    end
  end

  // one shared line; registered so it never glitches toward the host
  assign irq_nxt = |(norm_status & norm_signal_en_r); // [RQ9] [RQ14]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt; // [RQ9]
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign irq = irq_r;

endmodule // sd_host_interrupt_enables

// file: include/sd_irq_regs.vh
`ifndef SD_IRQ_REGS_VH
`define SD_IRQ_REGS_VH

// byte offsets on the 10-bit bus; two 16-bit registers share each word but the one at 0x038
`define NORM_STATUS_OFS 10'h030
`define ERR_STATUS_OFS 10'h032
`define NORM_STATUS_EN_OFS 10'h034
`define ERR_STATUS_EN_OFS 10'h036
`define NORM_SIGNAL_EN_OFS 10'h038
`define NORM_CLEAR_OFS 10'h040
`define ERR_CLEAR_OFS 10'h042

// writable bits of each enable register, the live normal status bits, and the enable reset value
`define NORM_STATUS_EN_MASK 16'h01FF
`define ERR_STATUS_EN_MASK 16'hF3FF
`define NORM_SIGNAL_EN_MASK 16'h01FF
`define NORM_STATUS_MASK 16'h01FF
`define REG_RESET 16'h0000

// normal status / enable bit positions
`define B_CMD_DONE 0
`define B_XFER_DONE 1
`define B_BLOCK_GAP 2
`define B_DMA_INT 3
`define B_BUF_WR_RDY 4
`define B_BUF_RD_RDY 5
`define B_CARD_INS 6
`define B_CARD_REM 7
`define B_CARD_INT 8
`define B_SIG_FIXED0 15

// error status / enable bit positions
`define E_CMD_TIMEOUT 0
`define E_CMD_CRC 1
`define E_CMD_END_BIT 2
`define E_CMD_INDEX 3
`define E_DATA_TIMEOUT 4
`define E_DATA_CRC 5
`define E_DATA_END_BIT 6
`define E_CUR_LIMIT 7
`define E_AUTO_STOP 8
`define E_ADMA 9
`define E_RSVD_LSB 10
`define E_RSVD_MSB 11
`define E_VENDOR_LSB 12
`define E_VENDOR_MSB 15

`endif

// file: logic/event_flag_bank.v
`timescale 1ns/1ps
module event_flag_bank #(
  parameter WIDTH = 16
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] event_in,
  input wire [WIDTH-1:0] status_en,
  input wire [WIDTH-1:0] clear_in,
  output wire [WIDTH-1:0] flags
);
  reg [WIDTH-1:0] flag_r;
  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      // a masked event never reaches the flag; a set in the clear cycle wins
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_r[i] <= 1'b0;
        end else if (event_in[i] && status_en[i]) begin
          flag_r[i] <= 1'b1;
        end else if (clear_in[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flag_r;
endmodule // event_flag_bank

// file: logic/card_int_sampler.v
`timescale 1ns/1ps
module card_int_sampler (
  input wire clk,
  input wire rst_n,
  input wire card_int_pin,
  input wire detect_en,
  output wire card_int_held
);
  reg sync1_r;
  reg sync2_r;
  reg held_r;

  // disabling wipes the whole chain, so no stale level survives re-enable
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      held_r <= 1'b0;
    end else if (!detect_en) begin
      sync1_r <= 1'b0; // [RQ2]
      sync2_r <= 1'b0; // [RQ2]
      held_r <= 1'b0; // [RQ13]
    end else begin
      sync1_r <= card_int_pin;
      sync2_r <= sync1_r;
      held_r <= sync2_r; // [RQ3]
    end
  end

  assign card_int_held = held_r;
endmodule // card_int_sampler

// file: verification/sd_host_interrupt_enables_checker.sv
`timescale 1ns/1ps
module sd_host_interrupt_enables_checker (
  input wire clk,
  input wire rst_n,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire rd_ack = avs_read && !avs_waitrequest;
  wire req = avs_read || avs_write;
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered on the next edge");
  chk_wait_bound: assert property ($rose(req) |-> ##[1:2] !avs_waitrequest)
    else $error("new request not answered in time");
  chk_wait_idle: assert property (!req |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  chk_sig_rsvd: assert property (rd_ack && avs_address == 10'h038 |->
    avs_readdata[31:9] == 23'h000000)
    else $error("signal enable reserved bits not zero");
  chk_err_rsvd: assert property (rd_ack && avs_address == 10'h034 |->
    avs_readdata[27:26] == 2'h0)
    else $error("error status enable reserved bits not zero");
  chk_sts_rsvd: assert property (rd_ack && avs_address == 10'h034 |->
    avs_readdata[15:9] == 7'h00)
    else $error("status enable upper bits not zero");
  chk_clear_zero: assert property (rd_ack && avs_address == 10'h040 |->
    avs_readdata == 32'h0000_0000)
    else $error("clear register read not zero");
  chk_irq_reset: assert property ($rose(rst_n) |-> !irq)
    else $error("irq high straight after reset");
  cover property ($rose(irq));
  cover property (rd_ack && avs_address == 10'h038);
  cover property (avs_write && !avs_waitrequest);
endmodule // sd_host_interrupt_enables_checker

bind sd_host_interrupt_enables sd_host_interrupt_enables_checker u_chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// file: verification/sd_host_interrupt_enables_tb.sv
`timescale 1ns/1ps
module sd_host_interrupt_enables_tb;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq, card_pin;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, vev;
  logic [7:0] nev;
  logic [9:0] eev;
  logic [15:0] q;
  int n_fail = 0;
  int n_tests = 0;
  logic [9:0] ra [3] = '{10'h034, 10'h036, 10'h038};
  logic [15:0] rm [3] = '{16'h01FF, 16'hF3FF, 16'h01FF};

  sd_host_interrupt_enables uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_complete_evt(nev[0]), .xfer_complete_evt(nev[1]),
    .block_gap_evt(nev[2]), .dma_int_evt(nev[3]), .buf_write_ready_evt(nev[4]),
    .buf_read_ready_evt(nev[5]), .card_insert_evt(nev[6]), .card_remove_evt(nev[7]),
    .card_int_pin(card_pin), .cmd_timeout_err_evt(eev[0]), .cmd_crc_err_evt(eev[1]),
    .cmd_end_bit_err_evt(eev[2]), .cmd_index_err_evt(eev[3]), .data_timeout_err_evt(eev[4]),
    .data_crc_err_evt(eev[5]), .data_end_bit_err_evt(eev[6]), .current_limit_err_evt(eev[7]),
    .auto_stop_err_evt(eev[8]), .adma_err_evt(eev[9]), .vendor_err_evt(vev), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input string nm, input [15:0] exp, input [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one request held until waitrequest is sampled low; bounded wait
  task bus(input w, input [9:0] a, input [15:0] d);
    int i;
    @(posedge clk);
    // word address; bit 1 of the register offset picks the half and its lanes
    avs_address <= {a[9:2], 2'b00};
    avs_byteenable <= a[1] ? 4'hC : 4'h3;
    avs_writedata <= a[1] ? {d, 16'h0000} : {16'h0000, d};
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_fail++;
      end_sim;
    end
    q = a[1] ? avs_readdata[31:16] : avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task pulse(input [7:0] n, input [9:0] e, input [3:0] v);
    @(posedge clk);
    nev <= n;
    eev <= e;
    vev <= v;
    @(posedge clk);
    nev <= 8'h00;
    eev <= 10'h000;
    vev <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  task t_reset;
    for (int k = 0; k < 3; k++) begin
      bus(0, ra[k], 16'h0000);
      chk("enable reset", 16'h0000, q);
    end
    chk("irq", 16'h0000, {15'h0000, irq});
    $display("test reset done");
  endtask

  task t_regs;
    for (int k = 0; k < 3; k++) begin
      bus(1, ra[k], 16'hFFFF);
      bus(1, 10'h3FC, 16'h0000);
      bus(0, ra[k], 16'h0000);
      chk("enable ones", rm[k], q);
      bus(0, ra[(k + 1) % 3], 16'h0000);
      chk("enable neighbour", 16'h0000, q);
      bus(1, ra[k], 16'h0000);
      bus(0, ra[k], 16'h0000);
      chk("enable zeros", 16'h0000, q);
    end
    bus(0, 10'h3FC, 16'h0000);
    chk("unmapped", 16'h0000, q);
    bus(0, 10'h040, 16'h0000);
    chk("clear reads", 16'h0000, q);
    $display("test registers done");
  endtask

  task t_mask;
    bus(1, 10'h034, 16'h0006);
    pulse(8'h07, 10'h000, 4'h0);
    bus(0, 10'h030, 16'h0000);
    chk("normal status", 16'h0006, q);
    bus(1, 10'h040, 16'h00FF);
    bus(0, 10'h030, 16'h0000);
    chk("normal cleared", 16'h0000, q);
    bus(1, 10'h036, 16'h1003);
    pulse(8'h00, 10'h3FF, 4'hF);
    bus(0, 10'h032, 16'h0000);
    chk("error status", 16'h1003, q);
    bus(1, 10'h042, 16'hFFFF);
    bus(0, 10'h032, 16'h0000);
    chk("error cleared", 16'h0000, q);
    bus(1, 10'h036, 16'h0000);
    $display("test masking done");
  endtask

  task t_irq;
    bus(1, 10'h034, 16'h00FF);
    pulse(8'hFF, 10'h000, 4'h0);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    for (int b = 0; b < 8; b++) begin
      bus(1, 10'h038, 16'h0001 << b);
      repeat (3) @(posedge clk);
      chk("irq one enable", 16'h0001, {15'h0000, irq});
    end
    bus(1, 10'h040, 16'h00FF);
    bus(1, 10'h038, 16'h00FF);
    repeat (3) @(posedge clk);
    chk("irq after clear", 16'h0000, {15'h0000, irq});
    bus(1, 10'h034, 16'h0000);
    $display("test interrupt done");
  endtask

  task t_card;
    bus(1, 10'h038, 16'h0100);
    card_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("card masked", 16'h0000, {15'h0000, irq});
    bus(1, 10'h034, 16'h0100);
    repeat (6) @(posedge clk);
    chk("card irq", 16'h0001, {15'h0000, irq});
    bus(0, 10'h030, 16'h0000);
    chk("card status", 16'h0100, q);
    bus(1, 10'h034, 16'h0000);
    repeat (3) @(posedge clk);
    chk("card withdrawn", 16'h0000, {15'h0000, irq});
    bus(0, 10'h030, 16'h0000);
    chk("card status off", 16'h0000, q);
    // chain was full of ones when disabled; a frozen chain would show them here
    card_pin <= 1'b0;
    bus(1, 10'h034, 16'h0100);
    bus(0, 10'h030, 16'h0000);
    chk("card stale", 16'h0000, q);
    card_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("card resumed", 16'h0001, {15'h0000, irq});
    card_pin <= 1'b0;
    $display("test card interrupt done");
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    nev = 8'h00;
    eev = 10'h000;
    vev = 4'h0;
    card_pin = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_mask;
    t_irq;
    t_card;
    end_sim;
  end
endmodule // sd_host_interrupt_enables_tb
